//--- verilog/spoc_pkg.sv
`default_nettype none

package spoc_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_IF_STATE = 8'h01;
   localparam logic [7:0] IDX_PWR_CTRL = 8'h02;
   localparam logic [7:0] IDX_SOCK_CFG = 8'h20;

   localparam int IDX_W = 8;
   localparam int IDX_LSB = 2;

   // reset values
   localparam logic [7:0] PWR_CTRL_RST = 8'h00;
   localparam logic [2:0] SOCK_CFG_RST = 3'h0;

   // socket config field positions
   localparam int CFG_VCC3_BIT = 0;
   localparam int CFG_AUTO_OFF_DIS_BIT = 1;
   localparam int CFG_IO_MODE_BIT = 2;

   // interface state field positions
   localparam int IFS_ONE_BIT = 7;
   localparam int IFS_PWR_ON_BIT = 6;
   localparam int IFS_READY_BIT = 5;
   localparam int IFS_PROTECT_BIT = 4;
   localparam int IFS_SENSE_B_BIT = 3;
   localparam int IFS_SENSE_A_BIT = 2;
   localparam int IFS_BATT_B_BIT = 1;
   localparam int IFS_BATT_A_BIT = 0;

   // programming rail codes
   localparam logic [1:0] RAIL_OFF = 2'h0;
   localparam logic [1:0] RAIL_FOLLOW = 2'h1;
   localparam logic [1:0] RAIL_PROG = 2'h2;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic card_en;
      logic compat_hi;
      logic auto_pwr;
      logic vcc_pwr;
      logic [1:0] compat_lo;
      logic [1:0] prog_rail_select_field;
   } spoc_pwr_ctrl_s;

   typedef struct packed {
      logic en;
      logic [IDX_W-1:0] idx;
      logic [31:0] data;
      logic [3:0] strb;
   } spoc_reg_wr_s;

   typedef enum logic [0:0] {
      WS_COLLECT,
      WS_RESP
   } spoc_wstate_e;

endpackage : spoc_pkg

`default_nettype wire

//--- verilog/spoc_axil_slave.sv
`default_nettype none

module spoc_axil_slave #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output spoc_pkg::spoc_reg_wr_s wr_req,
   input wire logic wr_hit,
   output logic [spoc_pkg::IDX_W-1:0] rd_idx,
   input wire logic rd_hit,
   input wire logic [31:0] rd_data
);

   localparam int TOP = spoc_pkg::IDX_W + spoc_pkg::IDX_LSB;

   spoc_pkg::spoc_wstate_e state_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   function automatic logic in_range(input logic [ADDR_W-1:0] a);
      in_range = (a >> TOP) == '0;
   endfunction : in_range

   wire both_held = (state_q == spoc_pkg::WS_COLLECT) & ~s_axi_awready & ~s_axi_wready;
   wire wr_ok = wr_hit & in_range(awaddr_q);
   wire rd_ok = rd_hit & in_range(s_axi_araddr);

   assign wr_req.en = both_held & wr_ok;
   assign wr_req.idx = awaddr_q[TOP-1:spoc_pkg::IDX_LSB];
   assign wr_req.data = wdata_q;
   assign wr_req.strb = wstrb_q;
   assign rd_idx = s_axi_araddr[TOP-1:spoc_pkg::IDX_LSB];

   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= spoc_pkg::WS_COLLECT;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= spoc_pkg::RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         case (state_q)
            spoc_pkg::WS_COLLECT: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  awaddr_q <= s_axi_awaddr;
                  s_axi_awready <= 1'b0;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  wdata_q <= s_axi_wdata;
                  wstrb_q <= s_axi_wstrb;
                  s_axi_wready <= 1'b0;
               end
               if (both_held) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_ok ? spoc_pkg::RESP_OKAY : spoc_pkg::RESP_SLVERR;
                  state_q <= spoc_pkg::WS_RESP;
               end
            end
            default: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
                  state_q <= spoc_pkg::WS_COLLECT;
               end
            end
         endcase
      end
   end

   // read channel: data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= spoc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_ok ? rd_data : 32'h0;
         s_axi_rresp <= rd_ok ? spoc_pkg::RESP_OKAY : spoc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule : spoc_axil_slave

`default_nettype wire

//--- verilog/spoc_power_ctrl.sv
// Functional notes
// (R1) memory mode: protect status bit shows card protect pin, 1 means protected.
// (R2) memory mode: ready status bit shows card ready pin, 1 means ready.
// (R3) power-on status bit is 1 exactly when supply controls are active.
// (R4) vcc power field 0 holds both supply selects high.
// (R5) vcc power 1 drives chosen supply select low per auto-power and detects.
// (R6) auto-power 0 ignores detects; auto-power 1 needs both detects low.
// (R7) rail field decode: 00/11 off, 01 follow high, 10 programming high.
// (R8) card removal clears vcc power unless auto-off is disabled.
// (R9) reset, vcc off or missing card with auto-power 1 keep selects high, rails low.
// (R10) card outputs float on reset or any detect high.
// (R11) card enable with card detected drives card outputs; table wins.
// (R12) card enable 0 floats all card outputs.
// (R13) detect status bits are inverted detect pins; both 1 means inserted.
// (R14) register write takes one cycle; socket outputs follow within one cycle.

`default_nettype none

module spoc_power_ctrl #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,

   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,

   input wire logic insert_sense_a_n,
   input wire logic insert_sense_b_n,
   input wire logic protect_or_wide_io_pin,
   input wire logic ready_or_card_irq_pin,
   input wire logic batt_sense_a_pin,
   input wire logic batt_sense_b_pin,

   output logic vcc_3v3_select_n,
   output logic vcc_5v_select_n,
   output logic prog_voltage_select,
   output logic vcc_follow_select,
   output logic card_out_oe_n
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------

   spoc_pkg::spoc_pwr_ctrl_s pwr_q;
   spoc_pkg::spoc_pwr_ctrl_s pwr_d;

   logic [2:0] cfg_q;
   logic [2:0] cfg_d;

   // detect state of the previous cycle, for removal detection
   logic inserted_q;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------

   spoc_pkg::spoc_reg_wr_s wr_req;
   logic wr_hit;
   logic [spoc_pkg::IDX_W-1:0] rd_idx;
   logic rd_hit;
   logic [31:0] rd_data;

   spoc_axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_req(wr_req),
      .wr_hit(wr_hit),
      .rd_idx(rd_idx),
      .rd_hit(rd_hit),
      .rd_data(rd_data)
   );

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------

   function automatic logic is_writable(input logic [spoc_pkg::IDX_W-1:0] idx);
      is_writable = (idx == spoc_pkg::IDX_PWR_CTRL) || (idx == spoc_pkg::IDX_SOCK_CFG);
   endfunction : is_writable

   function automatic logic is_readable(input logic [spoc_pkg::IDX_W-1:0] idx);
      is_readable = is_writable(idx) || (idx == spoc_pkg::IDX_IF_STATE);
   endfunction : is_readable

   // the status register is read only; a write to it answers an error
   assign wr_hit = is_writable(wr_req.idx);
   assign rd_hit = is_readable(rd_idx);

   // only byte lane 0 carries register data
   wire lane0 = wr_req.en & wr_req.strb[0];
   wire wr_pwr = lane0 & (wr_req.idx == spoc_pkg::IDX_PWR_CTRL); // R14
   wire wr_cfg = lane0 & (wr_req.idx == spoc_pkg::IDX_SOCK_CFG);

   // ------------------------------------------------------------
   // socket conditions
   // ------------------------------------------------------------

   wire sense_a = ~insert_sense_a_n; // R13
   wire sense_b = ~insert_sense_b_n; // R13
   wire inserted = sense_a & sense_b; // R13

   wire io_mode = cfg_q[spoc_pkg::CFG_IO_MODE_BIT];
   wire use_3v3 = cfg_q[spoc_pkg::CFG_VCC3_BIT];
   wire auto_off_dis = cfg_q[spoc_pkg::CFG_AUTO_OFF_DIS_BIT];

   // falling edge of full insertion means the card left the socket
   wire removed = inserted_q & ~inserted; // R8

   // supplies may be on: vcc field set and detect gating satisfied
   wire supply_on = pwr_q.vcc_pwr & (~pwr_q.auto_pwr | inserted); // R6 R9

   // ------------------------------------------------------------
   // next register values
   // ------------------------------------------------------------

   always_comb begin
      pwr_d = pwr_q;
      if (wr_pwr) begin
         pwr_d = spoc_pkg::spoc_pwr_ctrl_s'(wr_req.data[7:0]);
      end
      // removal wins over a write in the same cycle, so power stays off
      if (removed && !auto_off_dis) begin
         pwr_d.vcc_pwr = 1'b0; // R8
      end
   end

   always_comb begin
      cfg_d = cfg_q;
      if (wr_cfg) begin
         cfg_d = wr_req.data[2:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_q <= spoc_pkg::spoc_pwr_ctrl_s'(spoc_pkg::PWR_CTRL_RST);
         cfg_q <= spoc_pkg::SOCK_CFG_RST;
         inserted_q <= 1'b0;
      end else begin
         pwr_q <= pwr_d; // R14
         cfg_q <= cfg_d;
         inserted_q <= inserted;
      end
   end

   // ------------------------------------------------------------
   // supply select and rail outputs
   // ------------------------------------------------------------

   // supply selects are active low; only the chosen one drops
   wire sel3_d = ~(supply_on & use_3v3); // R4 R5
   wire sel5_d = ~(supply_on & ~use_3v3); // R4 R5

   // codes 00 and 11 leave both rail outputs low
   wire prog_d = supply_on & (pwr_q.prog_rail_select_field == spoc_pkg::RAIL_PROG); // R7
   wire follow_d = supply_on & (pwr_q.prog_rail_select_field == spoc_pkg::RAIL_FOLLOW); // R7

   // card outputs enabled only with both detects low and card enable set
   wire oe_n_d = ~(inserted & pwr_q.card_en); // R10 R11 R12

   // reset forces every socket pin to its safe level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vcc_3v3_select_n <= 1'b1; // R9
         vcc_5v_select_n <= 1'b1; // R9
         prog_voltage_select <= 1'b0; // R9
         vcc_follow_select <= 1'b0; // R9
         card_out_oe_n <= 1'b1; // R10
      end else begin
         vcc_3v3_select_n <= sel3_d;
         vcc_5v_select_n <= sel5_d;
         prog_voltage_select <= prog_d;
         vcc_follow_select <= follow_d;
         card_out_oe_n <= oe_n_d;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------

   logic [7:0] if_state;

   always_comb begin
      if_state = 8'h00;
      if_state[spoc_pkg::IFS_ONE_BIT] = 1'b1;
      if_state[spoc_pkg::IFS_PWR_ON_BIT] = supply_on; // R3
      // protect and ready are meaningless in io mode and read zero there
      if_state[spoc_pkg::IFS_READY_BIT] = ~io_mode & ready_or_card_irq_pin; // R2
      if_state[spoc_pkg::IFS_PROTECT_BIT] = ~io_mode & protect_or_wide_io_pin; // R1
      if_state[spoc_pkg::IFS_SENSE_B_BIT] = sense_b; // R13
      if_state[spoc_pkg::IFS_SENSE_A_BIT] = sense_a; // R13
      if_state[spoc_pkg::IFS_BATT_B_BIT] = batt_sense_b_pin;
      if_state[spoc_pkg::IFS_BATT_A_BIT] = batt_sense_a_pin;
   end

   always_comb begin
      if (rd_idx == spoc_pkg::IDX_IF_STATE) begin
         rd_data = {24'h0, if_state};
      end else if (rd_idx == spoc_pkg::IDX_PWR_CTRL) begin
         rd_data = {24'h0, pwr_q};
      end else if (rd_idx == spoc_pkg::IDX_SOCK_CFG) begin
         rd_data = {29'h0, cfg_q};
      end else begin
         rd_data = 32'h0;
      end
   end

endmodule : spoc_power_ctrl

`default_nettype wire

//--- tb/spoc_power_ctrl_monitor.sv
`default_nettype none

module spoc_power_ctrl_monitor #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic insert_sense_a_n,
   input wire logic insert_sense_b_n,
   input wire logic vcc_3v3_select_n,
   input wire logic vcc_5v_select_n,
   input wire logic prog_voltage_select,
   input wire logic vcc_follow_select,
   input wire logic card_out_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [ADDR_W-1:0] ar_q;
   logic stat_rd;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // address of the read now being answered
   always_ff @(posedge aclk) begin
      if (!aresetn) ar_q <= '0;
      else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
   end
   assign stat_rd = ar_q == ADDR_W'(12'h004);

   property p_rst_off;
      $past(!aresetn) |-> vcc_3v3_select_n && vcc_5v_select_n && !prog_voltage_select
         && !vcc_follow_select && card_out_oe_n;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("socket outputs active after reset");
   property p_sel_excl;
      !(!vcc_3v3_select_n && !vcc_5v_select_n);
   endproperty
   a_sel_excl: assert property (p_sel_excl) else $error("both supply selects active");
   property p_rail_excl;
      !(prog_voltage_select && vcc_follow_select);
   endproperty
   a_rail_excl: assert property (p_rail_excl) else $error("both rail outputs high");
   property p_rail_needs_vcc;
      prog_voltage_select || vcc_follow_select |-> !(vcc_3v3_select_n && vcc_5v_select_n);
   endproperty
   a_rail_needs_vcc: assert property (p_rail_needs_vcc) else $error("rail on without supply");
   property p_float;
      $past(insert_sense_a_n || insert_sense_b_n) |-> card_out_oe_n;
   endproperty
   a_float: assert property (p_float) else $error("card outputs driven without card");
   property p_stat_detect;
      $rose(s_axi_rvalid) && stat_rd |-> s_axi_rdata[3:2] == ~$past({insert_sense_b_n, insert_sense_a_n});
   endproperty
   a_stat_detect: assert property (p_stat_detect) else $error("detect status wrong");
   property p_stat_power;
      $rose(s_axi_rvalid) && stat_rd |-> s_axi_rdata[6] == !(vcc_3v3_select_n && vcc_5v_select_n);
   endproperty
   a_stat_power: assert property (p_stat_power) else $error("power on status wrong");
   property p_wr_latency;
      $fell(s_axi_wready) |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_wr_latency: assert property (p_wr_latency) else $error("write response late");
endmodule : spoc_power_ctrl_monitor

bind spoc_power_ctrl spoc_power_ctrl_monitor #(.ADDR_W(ADDR_W)) i_mon (.aclk(aclk), .aresetn(aresetn),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .insert_sense_a_n(insert_sense_a_n), .insert_sense_b_n(insert_sense_b_n),
   .vcc_3v3_select_n(vcc_3v3_select_n), .vcc_5v_select_n(vcc_5v_select_n),
   .prog_voltage_select(prog_voltage_select), .vcc_follow_select(vcc_follow_select),
   .card_out_oe_n(card_out_oe_n));

`default_nettype wire

//--- tb/spoc_card_model.sv
`default_nettype none

module spoc_card_model (
   input wire logic [1:0] seat,
   input wire logic wp,
   input wire logic rdy,
   input wire logic [1:0] bvd,
   output logic insert_sense_a_n,
   output logic insert_sense_b_n,
   output logic protect_or_wide_io_pin,
   output logic ready_or_card_irq_pin,
   output logic [1:0] batt_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // each detect contact grounds its pin once seated
   assign insert_sense_a_n = ~seat[0];
   assign insert_sense_b_n = ~seat[1];
   assign protect_or_wide_io_pin = wp;
   assign ready_or_card_irq_pin = rdy;
   assign batt_pin = bvd;
endmodule : spoc_card_model

`default_nettype wire

//--- tb/testbench.sv
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0] seat = 2'h0, bvd = 2'h0;
   logic wp = 1'b0, rdy = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sa_n, sb_n, wp_pin, rdy_pin, s3n, s5n, pg, fl, oen;
   logic [1:0] bresp, rresp, bv_pin;
   logic [31:0] rdata;
   int err_count = 0;
   int n_compared = 0;

   always #5 aclk = ~aclk;

   spoc_card_model i_card (.seat(seat), .wp(wp), .rdy(rdy), .bvd(bvd), .insert_sense_a_n(sa_n),
      .insert_sense_b_n(sb_n), .protect_or_wide_io_pin(wp_pin), .ready_or_card_irq_pin(rdy_pin),
      .batt_pin(bv_pin));

   spoc_power_ctrl #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .insert_sense_a_n(sa_n), .insert_sense_b_n(sb_n), .protect_or_wide_io_pin(wp_pin),
      .ready_or_card_irq_pin(rdy_pin), .batt_sense_a_pin(bv_pin[0]), .batt_sense_b_pin(bv_pin[1]),
      .vcc_3v3_select_n(s3n), .vcc_5v_select_n(s5n), .prog_voltage_select(pg),
      .vcc_follow_select(fl), .card_out_oe_n(oen));

   task summarize();
      if (err_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // handshakes are judged mid-cycle, where the registered answers are settled
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_take, w_take, b_take;
      logic [1:0] resp;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_take = awvalid & awready;
         w_take = wvalid & wready;
         b_take = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (aw_take) awvalid <= 1'b0;
         if (w_take) wvalid <= 1'b0;
      end while (b_take !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, resp}, {30'h0, r});
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ar_take, r_take;
      logic [31:0] data;
      logic [1:0] resp;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_take = arvalid & arready;
         r_take = rvalid;
         data = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ar_take) arvalid <= 1'b0;
      end while (r_take !== 1'b1);
      rready <= 1'b0;
      chk(data, e);
      chk({30'h0, resp}, {30'h0, r});
   endtask : rd

   // expected {3v3 sel_n, 5v sel_n, prog, follow, oe_n}, after outputs settle
   task outs(input logic [4:0] e);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({27'h0, s3n, s5n, pg, fl, oen}, {27'h0, e});
   endtask : outs

   task pins(input logic [1:0] s);
      @(posedge aclk);
      seat <= s;
   endtask : pins

   function automatic logic [31:0] st(input logic on);
      return {24'h0, 1'b1, on, rdy, wp, seat, bvd};
   endfunction : st

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h008, 32'h0, 2'h0);
      outs(5'b11001);
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk);
         wp <= i[0];
         rdy <= i[1];
         bvd <= i[1:0] ^ 2'h2;
         seat <= i[1:0];
         @(negedge aclk);
         rd(12'h004, st(1'b0), 2'h0);
      end
      wr(12'h008, 32'h80, 2'h0);
      outs(5'b11000);
      pins(2'h2);
      outs(5'b11001);
      pins(2'h0);
      for (int i = 0; i < 4; i++) begin
         wr(12'h008, {30'h4, i[1:0]}, 2'h0);
         outs({2'b10, i[1:0] == 2'h2, i[1:0] == 2'h1, 1'b1});
         rd(12'h004, st(1'b1), 2'h0);
      end
      wr(12'h080, 32'h1, 2'h0);
      outs(5'b01001);
      // auto power waits for full insertion
      wr(12'h008, 32'h32, 2'h0);
      outs(5'b11001);
      rd(12'h004, st(1'b0), 2'h0);
      pins(2'h1);
      outs(5'b11001);
      pins(2'h3);
      outs(5'b01101);
      pins(2'h1);
      outs(5'b11001);
      rd(12'h008, 32'h22, 2'h0);
      pins(2'h3);
      outs(5'b11001);
      wr(12'h080, 32'h3, 2'h0);
      wr(12'h008, 32'h32, 2'h0);
      pins(2'h0);
      rd(12'h008, 32'h32, 2'h0);
      wr(12'h004, 32'hff, 2'h2);
      // io card mode: protect and ready read zero
      wr(12'h080, 32'h7, 2'h0);
      rd(12'h004, 32'h81, 2'h0);
      rd(12'h00c, 32'h0, 2'h2);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h008, 32'h0, 2'h0);
      outs(5'b11001);
      summarize();
   end

   initial begin
      repeat (5000) @(posedge aclk);
      err_count++;
      summarize();
   end
endmodule : testbench

`default_nettype wire
